// File: hdl/processor_test_features.sv
// Built-in test logic: self-test, translation buffer test port, bus hold
// Function
// R1 - System holds self-test request active during initialization to ask for self-test.
// R2 - Self-test disables normal array inputs; LFSR steps through all input codes.
// R3 - Array and control ROM outputs feed a parallel-load signature register.
// R4 - Final signature XOR stored constant goes to result accumulator; zero passes.
// R5 - Buffer holds 32 entries: linear tag with attributes, 20-bit physical field.
// R6 - Four sets; 2-bit replacement pointer picks the set for each write with data bit 4 low.
// R7 - On hit, physical address is stored upper field plus 12 offset bits.
// R8 - Two 32-bit test registers reach the buffer via move instructions.
// R9 - Register six is command register; register seven is data register.
// R10 - Software disables translation before testing the buffer.
// R11 - Writing command starts an operation; bit 0 high looks up, low writes.
// R12 - Write stores data physical address, command linear and attributes at chosen set.
// R13 - Lookup hit copies physical address and sets hit flag; miss clears flag.
// R14 - Attribute bits: valid 11, modified 10/9, user 8/7, writable 6/5.
// R15 - Attribute and complement both low force miss; both high force hit.
// R16 - Software writes entries with each attribute opposite its complement.
// R17 - Replacement pointer advances after every buffer hit.
// R18 - Data bit 4 low uses replacement pointer, high uses data bits 3:2.
// R19 - Software loads data register first, then command with bit 0 clear.
// R20 - Software never enters one linear address twice.
// R21 - Lookup places hit and pointer in data bits 4:2; 31:12 valid on hit.
// R22 - On hold, finish current bus cycle, float outputs, raise acknowledge.
// R23 - Reset takes priority over pending or active hold request.
// R24 - On hold release, drop acknowledge and drive outputs before next cycle.
`timescale 1ns/1ns
`default_nettype none
module processor_test_features (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Self-test pin and array hookup
  input  wire logic                        self_test_request,
  output logic                             array_test_mode,
  output logic [test_pkg::STIM_W-1:0]      array_stimulus,
  input  wire logic [test_pkg::SIG_W-1:0]  array_response,
  output logic [31:0]                      result_accumulator,
  output logic                             self_test_done,
  // Test register moves
  input  wire logic                        treg_write,
  input  wire logic                        treg_read,
  input  wire logic [2:0]                  treg_num,
  input  wire logic [31:0]                 treg_wdata,
  output logic [31:0]                      treg_rdata,
  output logic                             treg_rvalid,
  // Normal translation
  input  wire logic                        xlat_valid,
  input  wire logic [31:0]                 xlat_linear,
  output logic                             xlat_hit,
  output logic [31:0]                      xlat_phys,
  // Bus hold
  input  wire logic                        hold_request,
  input  wire logic                        bus_cycle_active,
  output logic                             bus_hold_acknowledge,
  output logic                             bus_outputs_enable,
  output logic                             bus_cycle_permit
);
  import test_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN  = 3'h2,
    ST_DONE = 3'h4
  } st_state_t;

  typedef enum logic [2:0] {
    HOLD_RUN   = 3'h1,
    HOLD_DRAIN = 3'h2,
    HOLD_HELD  = 3'h4
  } hold_state_t;

  // Pin synchronisers: first stage feeds only the second
  logic [1:0]        pin_meta_q;
  logic [1:0]        pin_sync_q;
  logic              st_strap_q;
  logic              rst_seen_q;
  st_state_t         st_q;
  st_state_t         st_d;
  hold_state_t       hold_q;
  hold_state_t       hold_d;
  logic [TREG_W-1:0] cmd_q;
  logic [TREG_W-1:0] data_q;
  logic              op_pend_q;
  logic [SET_W-1:0]  ptr_q;
  logic [31:0]       result_q;
  logic [31:0]       rdata_q;
  logic              rvalid_q;
  logic              xhit_q;
  logic [31:0]       xphys_q;
  logic              eng_running;
  logic              eng_done;
  logic [SIG_W-1:0]  eng_sig;
  logic              tlb_hit;
  logic [PHYS_W-1:0] tlb_phys;

  wire logic st_req_sync = pin_sync_q[0];
  wire logic hold_sync   = pin_sync_q[1];

  // No reset: the strap must reach the latch while reset is still held
  always_ff @(posedge clk) begin
    pin_meta_q <= {hold_request, self_test_request};
    pin_sync_q <= pin_meta_q;
  end

  // Self-test: strap is caught while reset is held, run after release
  wire logic st_start = (st_q == ST_IDLE) && st_strap_q && rst_seen_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      st_strap_q <= st_req_sync;                  // [R1]
      rst_seen_q <= 1'b1;
    end else begin
      rst_seen_q <= 1'b0;
      if (st_start) begin
        st_strap_q <= 1'b0;
      end
    end
  end

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (st_start) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (eng_done) begin
          st_d = ST_DONE;
        end
      end
      ST_DONE: st_d = ST_DONE;
      default: st_d = ST_IDLE;
    endcase
  end

  self_test_engine u_engine (
    .clk       (clk),
    .rst       (rst),
    .start     (st_start),
    .running   (eng_running),
    .done      (eng_done),
    .stim      (array_stimulus),
    .response  (array_response),
    .signature (eng_sig)
  );

  // Test mode covers the whole run so normal inputs never leak in
  assign array_test_mode = (st_q == ST_RUN);     // [R2]

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q     <= ST_IDLE;
      result_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      if (eng_done) begin
        result_q <= eng_sig ^ SIG_CONST;          // [R4]
      end
    end
  end

  assign result_accumulator = result_q;
  assign self_test_done     = (st_q == ST_DONE);

  // Test register decode
  wire logic cmd_wr    = treg_write && (treg_num == TREG_CMD_NUM);   // [R9]
  wire logic data_wr   = treg_write && (treg_num == TREG_DATA_NUM);  // [R9]
  wire logic op_lookup = op_pend_q && cmd_q[CMD_OP_BIT];             // [R11]
  wire logic op_write  = op_pend_q && !cmd_q[CMD_OP_BIT];            // [R11]

  wire logic [ATTR_W-1:0] cmd_attr = cmd_q[CMD_ATTR_HI:CMD_ATTR_LO]; // [R14]
  wire logic [SET_W-1:0]  wr_set   = data_q[DATA_SEL_BIT] ?
                                     data_q[DATA_PTR_HI:DATA_PTR_LO] : ptr_q; // [R18]

  // Test operation owns the lookup port for its one cycle
  wire logic [31:0]       look_lin  = op_pend_q ? cmd_q : xlat_linear;
  wire logic [ATTR_W-1:0] look_attr = op_pend_q ? cmd_attr : ATTR_NORMAL;
  wire logic              xlat_take = xlat_valid && !op_pend_q;
  wire logic              any_hit   = tlb_hit && (op_lookup || xlat_take);
  wire logic [SET_W-1:0]  ptr_d     = any_hit ? ptr_q + 2'h1 : ptr_q;   // [R17]

  translation_buffer u_tlb (
    .clk         (clk),
    .rst         (rst),
    .wr_en       (op_write),                      // [R12]
    .wr_set      (wr_set),
    .wr_linear   (cmd_q),
    .wr_attr     (cmd_attr),
    .wr_phys     (data_q[31:PAGE_LSB]),
    .look_linear (look_lin),
    .look_attr   (look_attr),
    .hit         (tlb_hit),
    .hit_phys    (tlb_phys)
  );

  // A data write in the op cycle loses to the lookup result
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_q     <= CMD_RESET;
      data_q    <= DATA_RESET;
      op_pend_q <= 1'b0;
      ptr_q     <= PTR_RESET;
    end else begin
      op_pend_q <= cmd_wr;                        // [R11]
      ptr_q     <= ptr_d;                         // [R6]
      if (cmd_wr) begin
        cmd_q <= treg_wdata;                      // [R8]
      end
      if (op_lookup) begin
        data_q[DATA_HIT_BIT]             <= tlb_hit;   // [R13]
        data_q[DATA_PTR_HI:DATA_PTR_LO]  <= ptr_d;     // [R21]
        if (tlb_hit) begin
          data_q[31:PAGE_LSB] <= tlb_phys;        // [R13]
        end
      end else if (data_wr) begin
        data_q <= treg_wdata;                     // [R8]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
      xhit_q   <= 1'b0;
      xphys_q  <= 32'h0000_0000;
    end else begin
      rvalid_q <= treg_read;
      if (treg_read) begin
        rdata_q <= (treg_num == TREG_CMD_NUM)  ? cmd_q :
                   (treg_num == TREG_DATA_NUM) ? data_q : 32'h0000_0000;
      end
      xhit_q  <= xlat_take && tlb_hit;
      xphys_q <= {tlb_phys, xlat_linear[PAGE_LSB-1:0]};   // [R7]
    end
  end

  assign treg_rdata  = rdata_q;
  assign treg_rvalid = rvalid_q;
  assign xlat_hit    = xhit_q;
  assign xlat_phys   = xphys_q;

  // Bus hold: drain current cycle, then float until release
  always_comb begin
    hold_d = hold_q;
    case (hold_q)
      HOLD_RUN: begin
        if (hold_sync) begin
          hold_d = bus_cycle_active ? HOLD_DRAIN : HOLD_HELD;   // [R22]
        end
      end
      HOLD_DRAIN: begin
        if (!bus_cycle_active) begin
          hold_d = HOLD_HELD;
        end
      end
      HOLD_HELD: begin
        if (!hold_sync) begin
          hold_d = HOLD_RUN;                      // [R24]
        end
      end
      default: hold_d = HOLD_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hold_q <= HOLD_RUN;                         // [R23]
    end else begin
      hold_q <= hold_d;
    end
  end

  assign bus_hold_acknowledge = (hold_q == HOLD_HELD);              // [R22]
  assign bus_outputs_enable   = (hold_q != HOLD_HELD);              // [R22]
  assign bus_cycle_permit     = (hold_q == HOLD_RUN) && !hold_sync; // [R24]

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_granted;
    bus_hold_acknowledge && !bus_outputs_enable;
  endsequence

  sequence s_released;
    !bus_hold_acknowledge && bus_outputs_enable;
  endsequence

  a_hold_float_ack: assert property (bus_hold_acknowledge |-> !bus_outputs_enable) // [R22]
    else $error("acknowledge high while outputs driven");
  a_hold_waits_cycle: assert property ((hold_q == HOLD_RUN) && hold_sync && bus_cycle_active
    |=> !bus_hold_acknowledge) // [R22]
    else $error("hold granted during a bus cycle");
  a_hold_release: assert property (s_granted ##1 !hold_sync |=> s_released) // [R24]
    else $error("hold not released one cycle after request dropped");
  a_permit_driven: assert property (bus_cycle_permit |-> s_released) // [R24]
    else $error("bus cycle permitted while floating");
  a_lookup_hit: assert property (op_lookup && tlb_hit |=>
    data_q[DATA_HIT_BIT] && (data_q[31:PAGE_LSB] == $past(tlb_phys))) // [R13]
    else $error("lookup hit not reported");
  a_lookup_miss: assert property (op_lookup && !tlb_hit |=> !data_q[DATA_HIT_BIT]) // [R13]
    else $error("lookup miss left hit flag set");
  a_lookup_ptr: assert property (op_lookup |=>
    data_q[DATA_PTR_HI:DATA_PTR_LO] == ptr_q) // [R21]
    else $error("pointer not returned in data register");
  a_ptr_advance: assert property (any_hit |=> ptr_q == $past(ptr_q) + 2'h1) // [R17]
    else $error("pointer did not move after hit");
  a_write_set: assert property (op_write && !data_q[DATA_SEL_BIT] |-> wr_set == ptr_q) // [R18]
    else $error("write ignored replacement pointer");
  a_cmd_starts_op: assert property (cmd_wr |=> op_pend_q ##1 !op_pend_q || $past(cmd_wr)) // [R11]
    else $error("command write did not start one operation");
  a_phys_join: assert property (xlat_hit |->
    xlat_phys[PAGE_LSB-1:0] == $past(xlat_linear[PAGE_LSB-1:0])) // [R7]
    else $error("offset bits not carried into physical address");
  a_test_mode_run: assert property (eng_running |-> array_test_mode) // [R2]
    else $error("arrays not isolated during self-test");
  a_result_load: assert property (eng_done |=> result_q == ($past(eng_sig) ^ SIG_CONST)) // [R4]
    else $error("result accumulator not loaded from signature");
endmodule
`default_nettype wire

// File: hdl/self_test_engine.sv
// Pseudo-random stimulus sequencer and signature compressor for self-test
`timescale 1ns/1ns
`default_nettype none
module self_test_engine (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Control
  input  wire logic                        start,
  output logic                             running,
  output logic                             done,
  // Array stimulus and response
  output logic [test_pkg::STIM_W-1:0]      stim,
  input  wire logic [test_pkg::SIG_W-1:0]  response,
  output logic [test_pkg::SIG_W-1:0]       signature
);
  import test_pkg::*;

  logic [STIM_W-1:0] lfsr_q;
  logic [STIM_W-1:0] count_q;
  logic              run_q;
  logic              done_q;
  logic [SIG_W-1:0]  sig_q;

  // Zero-tail term adds the all-zero state, so all 256 codes appear
  wire logic              zero_tail = (lfsr_q[STIM_W-2:0] == '0);
  wire logic              lfsr_fb   = (^(lfsr_q & LFSR_TAPS)) ^ zero_tail;
  wire logic [STIM_W-1:0] lfsr_d    = {lfsr_q[STIM_W-2:0], lfsr_fb};
  wire logic [SIG_W-1:0]  sig_d     = {sig_q[SIG_W-2:0], ^(sig_q & MISR_TAPS)} ^ response;
  wire logic              last      = (count_q == STIM_LAST);

  always_ff @(posedge clk) begin
    if (rst) begin
      lfsr_q  <= LFSR_SEED;
      count_q <= '0;
      run_q   <= 1'b0;
      done_q  <= 1'b0;
      sig_q   <= MISR_SEED;
    end else begin
      done_q <= run_q && last;
      if (start && !run_q) begin
        lfsr_q  <= LFSR_SEED;
        count_q <= '0;
        run_q   <= 1'b1;
        sig_q   <= MISR_SEED;
      end else if (run_q) begin
        lfsr_q  <= lfsr_d;                        // [R2]
        sig_q   <= sig_d;                         // [R3]
        count_q <= count_q + 8'h01;
        if (last) begin
          run_q <= 1'b0;
        end
      end
    end
  end

  assign stim      = lfsr_q;
  assign running   = run_q;
  assign done      = done_q;
  assign signature = sig_q;
endmodule
`default_nettype wire

// File: hdl/test_pkg.sv
// Shared constants for the processor test features block
package test_pkg;
  // Test register numbers used by the move instructions
  localparam logic [2:0]  TREG_CMD_NUM  = 3'h6;
  localparam logic [2:0]  TREG_DATA_NUM = 3'h7;
  localparam int          TREG_W        = 32;
  // Command register fields
  localparam int          CMD_OP_BIT    = 0;
  localparam int          CMD_ATTR_HI   = 11;
  localparam int          CMD_ATTR_LO   = 5;
  localparam int          ATTR_W        = 7;
  // Attribute vector positions after extraction (V, D, ~D, U, ~U, W, ~W)
  localparam int          AT_V          = 6;
  localparam int          AT_D          = 5;
  localparam int          AT_DN         = 4;
  localparam int          AT_U          = 3;
  localparam int          AT_UN         = 2;
  localparam int          AT_W          = 1;
  localparam int          AT_WN         = 0;
  localparam logic [6:0]  ATTR_NORMAL   = 7'h7F;
  // Data register fields
  localparam int          DATA_HIT_BIT  = 4;
  localparam int          DATA_SEL_BIT  = 4;
  localparam int          DATA_PTR_HI   = 3;
  localparam int          DATA_PTR_LO   = 2;
  localparam int          PAGE_LSB      = 12;
  localparam int          PHYS_W        = 20;
  // Buffer organisation
  localparam int          SETS          = 4;
  localparam int          ROWS          = 8;
  localparam int          ROW_W         = 3;
  localparam int          SET_W         = 2;
  localparam int          TAG_W         = 17;
  localparam int          ENTRIES       = 32;
  // Reset values
  localparam logic [31:0] CMD_RESET     = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET    = 32'h0000_0000;
  localparam logic [1:0]  PTR_RESET     = 2'h0;
  // Self-test sequencer and signature
  localparam int          STIM_W        = 8;
  localparam int          SIG_W         = 32;
  localparam logic [7:0]  LFSR_TAPS     = 8'hB8;
  localparam logic [7:0]  LFSR_SEED     = 8'h01;
  localparam logic [7:0]  STIM_LAST     = 8'hFF;
  localparam logic [31:0] MISR_TAPS     = 32'h8020_0003;
  localparam logic [31:0] MISR_SEED     = 32'h0000_0000;
  // Stored signature constant; value is arbitrary
  localparam logic [31:0] SIG_CONST     = 32'h5A3C_96E1;
endpackage

// File: hdl/translation_buffer.sv
// Four-set, 32-entry translation buffer with attribute-aware lookup
`timescale 1ns/1ns
`default_nettype none
module translation_buffer (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // Write port
  input  wire logic                         wr_en,
  input  wire logic [test_pkg::SET_W-1:0]   wr_set,
  input  wire logic [31:0]                  wr_linear,
  input  wire logic [test_pkg::ATTR_W-1:0]  wr_attr,
  input  wire logic [test_pkg::PHYS_W-1:0]  wr_phys,
  // Lookup port
  input  wire logic [31:0]                  look_linear,
  input  wire logic [test_pkg::ATTR_W-1:0]  look_attr,
  output logic                              hit,
  output logic [test_pkg::PHYS_W-1:0]       hit_phys
);
  import test_pkg::*;

  logic [TAG_W-1:0]  tag_q  [0:ENTRIES-1];
  logic [3:0]        flag_q [0:ENTRIES-1];
  logic [PHYS_W-1:0] phys_q [0:ENTRIES-1];
  logic [SETS-1:0]   match;

  // Both low forces a miss, both high forces a hit
  function automatic logic pair_ok(input logic stored, input logic t, input logic tn);
    pair_ok = (t == tn) ? t : (stored == t);
  endfunction

  wire logic [ROW_W-1:0] look_row = look_linear[PAGE_LSB+ROW_W-1:PAGE_LSB];
  wire logic [TAG_W-1:0] look_tag = look_linear[31:PAGE_LSB+ROW_W];
  wire logic [4:0]       wr_idx   = {wr_set, wr_linear[PAGE_LSB+ROW_W-1:PAGE_LSB]};

  genvar s;
  generate
    for (s = 0; s < SETS; s++) begin : g_set
      wire logic [4:0] idx = {SET_W'(s), look_row};
      assign match[s] = (tag_q[idx] == look_tag)
                     && (flag_q[idx][3] == look_attr[AT_V])
                     && pair_ok(flag_q[idx][2], look_attr[AT_D], look_attr[AT_DN])
                     && pair_ok(flag_q[idx][1], look_attr[AT_U], look_attr[AT_UN])
                     && pair_ok(flag_q[idx][0], look_attr[AT_W], look_attr[AT_WN]); // [R15]
    end
  endgenerate

  // Lowest matching set wins; duplicate entries are software's fault
  wire logic [1:0] hit_set = match[0] ? 2'h0 : match[1] ? 2'h1 : match[2] ? 2'h2 : 2'h3;

  assign hit      = |match;
  assign hit_phys = phys_q[{hit_set, look_row}];

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < ENTRIES; i++) begin
        tag_q[i]  <= '0;
        flag_q[i] <= 4'h0;
        phys_q[i] <= '0;
      end
    end else if (wr_en) begin
      tag_q[wr_idx]  <= wr_linear[31:PAGE_LSB+ROW_W];   // [R5]
      flag_q[wr_idx] <= {wr_attr[AT_V], wr_attr[AT_D], wr_attr[AT_U], wr_attr[AT_W]};
      phys_q[wr_idx] <= wr_phys;
    end
  end
endmodule
`default_nettype wire

// File: test/far_side_model.sv
// Far-side model: self-test strap and array response
`timescale 1ns/1ns
`default_nettype none
module far_side_model (
  // Strap
  input  wire logic                        rst,
  output logic                             self_test_request,
  // Array hookup
  input  wire logic [test_pkg::STIM_W-1:0] array_stimulus,
  output logic [test_pkg::SIG_W-1:0]       array_response
);
  import test_pkg::*;
  // Strap held only while initializing, so a late sample sees it low
  assign self_test_request = rst;
  // Any fixed function of the stimulus serves for folding
  assign array_response = {array_stimulus, ~array_stimulus, array_stimulus ^ 8'hA5, 8'h3C};
endmodule
`default_nettype wire

// File: test/test_processor_test_features.sv
// Self-checking bench for the processor test features block
`timescale 1ns/1ns
`default_nettype none
module test_processor_test_features;
  import test_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [6:0]  AOK = 7'h5A;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        tw = 1'b0;
  logic        tr = 1'b0;
  logic [2:0]  tnum = 3'h0;
  logic [31:0] twd = 32'h0;
  logic        xv = 1'b0;
  logic [31:0] xl = 32'h0;
  logic        hreq = 1'b0;
  logic        bca = 1'b0;
  logic        st_req, mode, st_done, trv, xh, ack, oe, permit;
  logic [7:0]  stim;
  logic [31:0] resp, result, trd, xp, res_q;
  logic [31:0] sig = MISR_SEED;
  logic [31:0] q_exp[$];
  logic [31:0] q_msk[$];
  logic [19:0] phys [4];
  logic [16:0] tag;
  logic [1:0]  ptr = PTR_RESET;
  logic        seen [256];
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          n;
  int          k;
  always #5 clk = ~clk;
  processor_test_features dut_u (.clk(clk), .rst(rst), .self_test_request(st_req),
    .array_test_mode(mode), .array_stimulus(stim), .array_response(resp),
    .result_accumulator(result), .self_test_done(st_done), .treg_write(tw),
    .treg_read(tr), .treg_num(tnum), .treg_wdata(twd), .treg_rdata(trd),
    .treg_rvalid(trv), .xlat_valid(xv), .xlat_linear(xl), .xlat_hit(xh),
    .xlat_phys(xp), .hold_request(hreq), .bus_cycle_active(bca),
    .bus_hold_acknowledge(ack), .bus_outputs_enable(oe), .bus_cycle_permit(permit));
  far_side_model far_u (.rst(rst), .self_test_request(st_req), .array_stimulus(stim),
    .array_response(resp));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    cmp(q_exp.size(), 32'h0);
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic twr(input logic [2:0] num, input logic [31:0] d);
    @(negedge clk);
    tw = 1'b1;
    tnum = num;
    twd = d;
    @(negedge clk);
    tw = 1'b0;
  endtask
  // Expectation noted first; the monitor pairs it with the answer
  task automatic rd(input logic [2:0] num, input logic [31:0] e, input logic [31:0] m);
    q_exp.push_back(e & m);
    q_msk.push_back(m);
    @(negedge clk);
    tr = 1'b1;
    tnum = num;
    @(negedge clk);
    tr = 1'b0;
  endtask
  task automatic put(input logic [19:0] lin, input logic [19:0] ph, input logic [2:0] sel);
    twr(3'h7, {ph, 7'h0, sel, 2'h0});
    twr(3'h6, {lin, AOK, 5'h0});
    @(negedge clk);
  endtask
  // Hit flag and pointer field, plus the physical field on a hit; other low bits are not defined by the format
  task automatic look(input logic [19:0] lin, input logic [6:0] at, input logic h,
                      input logic [19:0] ph);
    twr(3'h6, {lin, at, 4'h0, 1'b1});
    @(negedge clk);
    if (h) begin
      ptr = ptr + 2'h1;
    end
    rd(3'h7, {ph, 7'h0, h, ptr, 2'h0}, h ? 32'hFFFF_F01C : 32'h0000_001C);
  endtask
  task automatic wait_ack(input logic v);
    for (int i = 0; i < 8 && ack !== v; i++) @(negedge clk);
  endtask
  always @(negedge clk) begin
    if (trv === 1'b1) begin
      if (q_exp.size() > 0) begin
        cmp(trd & q_msk.pop_front(), q_exp.pop_front());
      end else begin
        cmp({31'h0, trv}, 32'h0);
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    k = $urandom(68833);
    repeat (12) @(negedge clk);
    rst = 1'b0;
    n = 0;
    while (st_done !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
      if (mode === 1'b1) begin
        seen[stim] = 1'b1;
        // Only the first 256 codes are folded; the last sample is past the run
        if (n <= 256) begin
          sig = {sig[30:0], ^(sig & MISR_TAPS)} ^ resp;
        end
      end
    end
    cmp(n, 32'h102);
    cmp(result, sig ^ SIG_CONST);
    cmp(mode, 1'b0);
    k = 0;
    foreach (seen[i]) if (seen[i] === 1'b1) k++;
    cmp(k, 32'h100);
    res_q = result;
    rd(3'h6, CMD_RESET, ALL);
    rd(3'h7, DATA_RESET, ALL);
    twr(3'h3, $urandom);
    rd(3'h3, 32'h0, ALL);
    tag = $urandom;
    for (int s = 0; s < 4; s++) begin
      phys[s] = $urandom;
      put({17'(tag + s), 3'h5}, phys[s], {1'b1, 2'(s)});
    end
    for (int s = 0; s < 4; s++) look({17'(tag + s), 3'h5}, AOK, 1'b1, phys[s]);
    look({17'(tag + 9), 3'h5}, AOK, 1'b0, 20'h0);
    look({tag, 3'h5}, 7'h4A, 1'b0, 20'h0);
    look({17'(tag + 1), 3'h5}, 7'h7A, 1'b1, phys[1]);
    rd(3'h6, {17'(tag + 1), 3'h5, 7'h7A, 4'h0, 1'b1}, ALL);
    @(negedge clk);
    xv = 1'b1;
    xl = {tag, 3'h5, 12'h3A7};
    @(negedge clk);
    ptr = ptr + 2'h1;
    cmp(xh, 1'b1);
    cmp(xp, {phys[0], 12'h3A7});
    xl = {17'(tag + 9), 3'h5, 12'h3A7};
    @(negedge clk);
    xv = 1'b0;
    cmp(xh, 1'b0);
    put({tag, 3'h2}, ~phys[0], 3'h0);
    look({tag, 3'h2}, AOK, 1'b1, ~phys[0]);
    bca = 1'b1;
    hreq = 1'b1;
    repeat (6) @(negedge clk);
    cmp({ack, oe, permit}, 3'b010);
    bca = 1'b0;
    wait_ack(1'b1);
    cmp({ack, oe}, 2'b10);
    hreq = 1'b0;
    wait_ack(1'b0);
    cmp({ack, oe, permit}, 3'b011);
    cmp(result, res_q);
    hreq = 1'b1;
    wait_ack(1'b1);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    cmp({ack, oe}, 2'b01);
    close_out();
  end
endmodule
`default_nettype wire
